// >>> shared/spml_pkg.sv
package spml_pkg;

  // Clock rate
  localparam int          MCLK_MHZ        = 40;

  // Reset pulse width limits on the device reset pin (ns)
  localparam int          PARTIAL_MIN_NS  = 50;
  localparam int          FULL_MIN_NS     = 1200;
  // Least times round up to whole cycles
  localparam int          PARTIAL_MIN_CYC = (PARTIAL_MIN_NS * MCLK_MHZ + 999) / 1000;
  localparam int          FULL_MIN_CYC    = (FULL_MIN_NS * MCLK_MHZ + 999) / 1000;
  localparam int          RST_CNT_W       = 16;

  // Range/mode select codes
  localparam logic [1:0]  MODE_SOFTWARE   = 2'h0;
  localparam logic [1:0]  RANGE_2V5       = 2'h1;
  localparam logic [1:0]  RANGE_5V        = 2'h2;
  localparam logic [1:0]  RANGE_10V       = 2'h3;

  // Parallel data low nibble layout
  localparam int          DB_LO_W         = 4;
  localparam int          CONV_LSB_POS    = 2;
  localparam logic [1:0]  DB_PAD_ZERO     = 2'h0;
  localparam logic [3:0]  DB_OE_N_OFF     = 4'hF;
  localparam logic [3:0]  DB_OE_N_ON      = 4'h0;

  // Reset values of the latched straps and of the input range
  localparam logic        REF_SEL_RST     = 1'b1;
  localparam logic        SEQ_EN_RST      = 1'b0;
  localparam logic        SW_MODE_RST     = 1'b1;
  localparam logic        SERIAL_RST      = 1'b0;
  localparam logic [1:0]  RANGE_RST       = 2'h3;

  typedef enum logic [1:0] {
    SPML_PIN_HIGH = 2'b01,
    SPML_PIN_LOW  = 2'b10
  } spml_rst_state_e;

endpackage

// >>> shared/spml_rst_if.sv
`timescale 1ns/1ps
interface spml_rst_if;
  logic full_release;
  logic partial_release;
  logic shutdown;

  modport src
  (
    output full_release,
    output partial_release,
    output shutdown
  );
  modport snk
  (
    input  full_release,
    input  partial_release,
    input  shutdown
  );
endinterface

// >>> rtl/spml_reset_classifier.sv
`timescale 1ns/1ps
module spml_reset_classifier #(
  parameter int PARTIAL_MIN_CYC = spml_pkg::PARTIAL_MIN_CYC,
  parameter int FULL_MIN_CYC    = spml_pkg::FULL_MIN_CYC
)(
  input  wire logic  mclk,
  input  wire logic  rst_n,
  input  wire logic  reset_pin_n,
  spml_rst_if.src    rst_bus
);

  localparam logic [spml_pkg::RST_CNT_W-1:0] PART_C = spml_pkg::RST_CNT_W'(PARTIAL_MIN_CYC);
  localparam logic [spml_pkg::RST_CNT_W-1:0] FULL_C = spml_pkg::RST_CNT_W'(FULL_MIN_CYC);

  spml_pkg::spml_rst_state_e        state_q, state_d;
  logic [spml_pkg::RST_CNT_W-1:0]   cnt_q, cnt_d;
  logic                             boot_q, boot_d;
  logic                             full_q, full_d;
  logic                             part_q, part_d;
  logic                             shut_q, shut_d;

  always_comb
  begin
    state_d = state_q;
    cnt_d   = cnt_q;
    boot_d  = 1'b0;
    full_d  = boot_q;
    part_d  = 1'b0;
    shut_d  = !reset_pin_n;
    case (state_q)
      spml_pkg::SPML_PIN_HIGH:
      begin
        cnt_d = '0;
        if (!reset_pin_n)
        begin
          state_d = spml_pkg::SPML_PIN_LOW;
          cnt_d   = spml_pkg::RST_CNT_W'(1);
        end
      end
      spml_pkg::SPML_PIN_LOW:
      begin
        if (!reset_pin_n)
        begin
          if (cnt_q < FULL_C)
            cnt_d = cnt_q + spml_pkg::RST_CNT_W'(1);
        end
        else
        begin
          // Pulse width picks the reset kind
          state_d = spml_pkg::SPML_PIN_HIGH;
          cnt_d   = '0;
          if (cnt_q >= FULL_C)
            full_d = 1'b1;
          else if (cnt_q >= PART_C)
            part_d = 1'b1;
        end
      end
      default:
      begin
        state_d = spml_pkg::SPML_PIN_HIGH;
        cnt_d   = '0;
      end
    endcase
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      state_q <= spml_pkg::SPML_PIN_HIGH;
      cnt_q   <= '0;
      boot_q  <= 1'b1;
      full_q  <= 1'b0;
      part_q  <= 1'b0;
      shut_q  <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      boot_q  <= boot_d;
      full_q  <= full_d;
      part_q  <= part_d;
      shut_q  <= shut_d;
    end
  end

  assign rst_bus.full_release    = full_q;
  assign rst_bus.partial_release = part_q;
  assign rst_bus.shutdown        = shut_q;

  a_shutdown_level: assert property (@(posedge mclk) disable iff (!rst_n)
    !reset_pin_n |=> shut_q) else $error("shutdown not shown while reset pin low");
  a_kind_exclusive: assert property (@(posedge mclk) disable iff (!rst_n)
    !(full_q && part_q)) else $error("full and partial reset together");
  a_short_partial: assert property (@(posedge mclk) disable iff (!rst_n)
    (state_q == spml_pkg::SPML_PIN_LOW && reset_pin_n && cnt_q >= PART_C && cnt_q < FULL_C)
    |=> part_q && !full_q) else $error("mid pulse not taken as partial reset");

endmodule

// >>> rtl/spml_strap_latch.sv
`timescale 1ns/1ps
// Overview of operation
// - A latched high reference select enables and selects the internal reference.
// - A latched low reference select disables the internal reference; the board then feeds the reference pin.
// - The reference select is sampled only when a full reset is released and is held until the next one.
// - The length of the low pulse on the reset pin decides between a full and a partial reset.
// - While the reset pin stays low the device is held in shutdown.
// - In hardware mode a low latched sequencer enable turns the sequencer off until another full reset.
// - In hardware mode a high latched sequencer enable turns on the sequencer with its reduced feature set.
// - Hardware or software mode is decided from the two range/mode pins and latched only at full reset.
// - In hardware mode the input range follows the range/mode pins live, without latching.
// - Code 00 on the range/mode pins selects software mode, with configuration taken from registers.
// - In hardware mode codes 01, 10 and 11 give ranges of 2.5 V, 5 V and 10 V either way.
// - Interface type low picks parallel, high picks serial, latched at full reset release.
// - In parallel mode the conversion LSB sits on data bit two and data bits zero and one drive zero.
// - In software parallel mode data bits zero to three carry the low four bits of each register transfer.
module spml_strap_latch #(
  parameter int PARTIAL_MIN_CYC = spml_pkg::PARTIAL_MIN_CYC,
  parameter int FULL_MIN_CYC    = spml_pkg::FULL_MIN_CYC
)(
  input  wire logic        mclk,
  input  wire logic        rst_n,
  input  wire logic        reset_pin_n,
  input  wire logic        ref_source_select,
  input  wire logic        sequencer_enable_pin,
  input  wire logic        range_mode_select_hi,
  input  wire logic        range_mode_select_lo,
  input  wire logic        interface_type_select,
  input  wire logic [1:0]  sw_range_cfg,
  input  wire logic [1:0]  conv_lsbs,
  input  wire logic        conv_read,
  input  wire logic        reg_read,
  input  wire logic [3:0]  reg_rd_low,
  input  wire logic        reg_write,
  input  wire logic [3:0]  db_low_in,
  output logic             shutdown_q,
  output logic             full_reset_done_q,
  output logic             partial_reset_done_q,
  output logic             int_ref_enable_q,
  output logic             ref_in_out_pin_oe_n_q,
  output logic             sequencer_on_q,
  output logic             sequencer_reduced_q,
  output logic             software_mode_q,
  output logic             serial_mode_q,
  output logic [1:0]       input_range_q,
  output logic [3:0]       reg_wr_low_q,
  output logic [3:0]       db_low_out_q,
  output logic [3:0]       db_low_oe_n_q
);

  spml_rst_if rst_bus ();

  spml_reset_classifier #(
    .PARTIAL_MIN_CYC (PARTIAL_MIN_CYC),
    .FULL_MIN_CYC    (FULL_MIN_CYC)
  ) u_classifier (
    .mclk        (mclk),
    .rst_n       (rst_n),
    .reset_pin_n (reset_pin_n),
    .rst_bus     (rst_bus)
  );

  logic [1:0] mode_pins;
  logic       ref_d, oe_ref_d, seq_on_d, seq_red_d, sw_d, ser_d;
  logic [1:0] range_d;
  logic [3:0] wr_d, dout_d, doe_d;
  logic       full_d, part_d, shut_d;

  assign mode_pins = {range_mode_select_hi, range_mode_select_lo};

  // Latched strap group
  always_comb
  begin
    ref_d     = int_ref_enable_q;
    seq_on_d  = sequencer_on_q;
    seq_red_d = sequencer_reduced_q;
    sw_d      = software_mode_q;
    ser_d     = serial_mode_q;
    if (rst_bus.full_release)
    begin
      ref_d     = ref_source_select;
      sw_d      = (mode_pins == spml_pkg::MODE_SOFTWARE);
      // Sequencer strap has effect in hardware mode only
      seq_on_d  = !sw_d && sequencer_enable_pin;
      seq_red_d = !sw_d && sequencer_enable_pin;
      ser_d     = interface_type_select;
    end
    oe_ref_d = !ref_d;
  end

  // Live range and pin drive group
  always_comb
  begin
    range_d = sw_range_cfg;
    if (!sw_d)
      range_d = mode_pins;
    wr_d   = reg_wr_low_q;
    dout_d = db_low_out_q;
    doe_d  = spml_pkg::DB_OE_N_OFF;
    if (!ser_d && !rst_bus.shutdown)
    begin
      if (sw_d && reg_write)
        wr_d = db_low_in;
      if (sw_d && reg_read)
      begin
        dout_d = reg_rd_low;
        doe_d  = spml_pkg::DB_OE_N_ON;
      end
      else if (conv_read)
      begin
        dout_d = {conv_lsbs, spml_pkg::DB_PAD_ZERO};
        doe_d  = spml_pkg::DB_OE_N_ON;
      end
    end
    // Serial mode: low data pins are tied off by the board, left undriven here
    full_d = rst_bus.full_release;
    part_d = rst_bus.partial_release;
    shut_d = rst_bus.shutdown;
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      int_ref_enable_q      <= spml_pkg::REF_SEL_RST;
      ref_in_out_pin_oe_n_q <= !spml_pkg::REF_SEL_RST;
      sequencer_on_q        <= spml_pkg::SEQ_EN_RST;
      sequencer_reduced_q   <= spml_pkg::SEQ_EN_RST;
      software_mode_q       <= spml_pkg::SW_MODE_RST;
      serial_mode_q         <= spml_pkg::SERIAL_RST;
      input_range_q         <= spml_pkg::RANGE_RST;
      reg_wr_low_q          <= '0;
      db_low_out_q          <= '0;
      db_low_oe_n_q         <= spml_pkg::DB_OE_N_OFF;
      full_reset_done_q     <= 1'b0;
      partial_reset_done_q  <= 1'b0;
      shutdown_q            <= 1'b0;
    end
    else
    begin
      int_ref_enable_q      <= ref_d;
      ref_in_out_pin_oe_n_q <= oe_ref_d;
      sequencer_on_q        <= seq_on_d;
      sequencer_reduced_q   <= seq_red_d;
      software_mode_q       <= sw_d;
      serial_mode_q         <= ser_d;
      input_range_q         <= range_d;
      reg_wr_low_q          <= wr_d;
      db_low_out_q          <= dout_d;
      db_low_oe_n_q         <= doe_d;
      full_reset_done_q     <= full_d;
      partial_reset_done_q  <= part_d;
      shutdown_q            <= shut_d;
    end
  end

  a_ref_sampled: assert property (@(posedge mclk) disable iff (!rst_n)
    rst_bus.full_release |=> int_ref_enable_q == $past(ref_source_select)
    && ref_in_out_pin_oe_n_q == !$past(ref_source_select))
    else $error("reference select not latched at full reset");
  a_ref_held: assert property (@(posedge mclk) disable iff (!rst_n)
    !rst_bus.full_release |=> $stable(int_ref_enable_q) && $stable(serial_mode_q) && $stable(software_mode_q))
    else $error("latched strap changed without full reset");
  a_mode_decode: assert property (@(posedge mclk) disable iff (!rst_n)
    rst_bus.full_release |=> software_mode_q == ($past(mode_pins) == spml_pkg::MODE_SOFTWARE))
    else $error("hardware/software mode decoded wrongly");
  a_seq_gate: assert property (@(posedge mclk) disable iff (!rst_n)
    rst_bus.full_release |=> sequencer_on_q == (!software_mode_q && $past(sequencer_enable_pin)))
    else $error("sequencer enable latched wrongly");
  a_range_live: assert property (@(posedge mclk) disable iff (!rst_n)
    (!software_mode_q && !rst_bus.full_release) |=> input_range_q == $past(mode_pins))
    else $error("hardware range does not follow pins");
  a_par_lsb: assert property (@(posedge mclk) disable iff (!rst_n)
    (!serial_mode_q && !rst_bus.full_release && !rst_bus.shutdown && conv_read && !(software_mode_q && reg_read))
    |=> db_low_out_q == {$past(conv_lsbs), 2'h0} && db_low_oe_n_q == 4'h0)
    else $error("conversion LSB not on data bit two");
  a_reg_nibble: assert property (@(posedge mclk) disable iff (!rst_n)
    (!serial_mode_q && software_mode_q && !rst_bus.full_release && !rst_bus.shutdown && reg_write)
    |=> reg_wr_low_q == $past(db_low_in))
    else $error("register write low nibble lost");
  a_ser_quiet: assert property (@(posedge mclk) disable iff (!rst_n)
    (serial_mode_q && !rst_bus.full_release) |=> db_low_oe_n_q == 4'hF)
    else $error("low data pins driven in serial mode");
  a_ref_pin_oe: assert property (@(posedge mclk) disable iff (!rst_n)
    ref_in_out_pin_oe_n_q == !int_ref_enable_q)
    else $error("reference pin drive disagrees with internal reference");
  a_hw_seq_off: assert property (@(posedge mclk) disable iff (!rst_n)
    (rst_bus.full_release && !sequencer_enable_pin) |=> !sequencer_on_q)
    else $error("sequencer on with low strap");
  a_seq_sw_off: assert property (@(posedge mclk) disable iff (!rst_n)
    software_mode_q |-> !sequencer_on_q && !sequencer_reduced_q)
    else $error("sequencer on in software mode");
  a_partial_keeps: assert property (@(posedge mclk) disable iff (!rst_n)
    rst_bus.partial_release |=> $stable(int_ref_enable_q) && $stable(software_mode_q) && $stable(sequencer_on_q))
    else $error("partial reset changed a latched strap");
  a_sw_range: assert property (@(posedge mclk) disable iff (!rst_n)
    (software_mode_q && !rst_bus.full_release) |=> input_range_q == $past(sw_range_cfg))
    else $error("software range not taken from registers");
  a_serial_latch: assert property (@(posedge mclk) disable iff (!rst_n)
    rst_bus.full_release |=> serial_mode_q == $past(interface_type_select))
    else $error("interface type not latched at full reset");
  a_read_nibble: assert property (@(posedge mclk) disable iff (!rst_n)
    (!serial_mode_q && software_mode_q && !rst_bus.full_release && !rst_bus.shutdown && reg_read)
    |=> db_low_out_q == $past(reg_rd_low) && db_low_oe_n_q == 4'h0)
    else $error("register read low nibble not driven");
  a_write_hold: assert property (@(posedge mclk) disable iff (!rst_n)
    !reg_write |=> $stable(reg_wr_low_q))
    else $error("write nibble changed without a write");
  a_shut_quiet: assert property (@(posedge mclk) disable iff (!rst_n)
    rst_bus.shutdown |=> db_low_oe_n_q == 4'hF)
    else $error("data pins driven in shutdown");
  a_idle_release: assert property (@(posedge mclk) disable iff (!rst_n)
    (!conv_read && !reg_read) |=> db_low_oe_n_q == 4'hF)
    else $error("data pins driven with no read");
  a_full_done: assert property (@(posedge mclk) disable iff (!rst_n)
    rst_bus.full_release |=> full_reset_done_q && !partial_reset_done_q)
    else $error("full reset done pulse missing");
  a_partial_done: assert property (@(posedge mclk) disable iff (!rst_n)
    rst_bus.partial_release |=> partial_reset_done_q && !full_reset_done_q)
    else $error("partial reset done pulse missing");

endmodule

// >>> tb/spml_board_model.sv
`timescale 1ns/1ps
module spml_board_model (
  input  wire logic        want_ref,
  input  wire logic        want_seq,
  input  wire logic [1:0]  want_range,
  input  wire logic        want_serial,
  input  wire logic [3:0]  host_data,
  input  wire logic [3:0]  db_low_out_q,
  input  wire logic [3:0]  db_low_oe_n_q,
  input  wire logic        ref_in_out_pin_oe_n_q,
  output logic             ref_source_select,
  output logic             sequencer_enable_pin,
  output logic             range_mode_select_hi,
  output logic             range_mode_select_lo,
  output logic             interface_type_select,
  output logic             ext_ref_driven,
  output logic [3:0]       db_low_in
);
  always_comb
  begin
    ref_source_select = want_ref;
    // Board feeds the reference pin whenever the device lets go of it
    ext_ref_driven = ref_in_out_pin_oe_n_q;
    sequencer_enable_pin = (want_range == spml_pkg::MODE_SOFTWARE) ? 1'b0 : want_seq;
    {range_mode_select_hi, range_mode_select_lo} = want_range;
    interface_type_select = want_serial;
    for (int i = 0; i < 4; i++)
    begin
      if (want_serial)
        db_low_in[i] = 1'b0;
      else
        db_low_in[i] = db_low_oe_n_q[i] ? host_data[i] : db_low_out_q[i];
    end
  end
endmodule

// >>> tb/strap_pin_mode_latch_bench.sv
`timescale 1ns/1ps
module strap_pin_mode_latch_bench;
  localparam int FULL_CYC = 6;
  logic mclk, rst_n, reset_pin_n, want_ref, want_seq, want_serial;
  logic [1:0] want_range, sw_range_cfg, conv_lsbs;
  logic [3:0] host_data, reg_rd_low, db_low_in;
  logic conv_read, reg_read, reg_write;
  logic ref_sel, seq_pin, rng_hi, rng_lo, if_sel, ext_ref;
  logic shutdown_q, full_reset_done_q, partial_reset_done_q, int_ref_enable_q;
  logic ref_in_out_pin_oe_n_q, sequencer_on_q, sequencer_reduced_q, software_mode_q, serial_mode_q;
  logic [1:0] input_range_q;
  logic [3:0] reg_wr_low_q, db_low_out_q, db_low_oe_n_q;
  int n_fail = 0;
  int tests_run = 0;
  int cyc = 0;

  spml_strap_latch #(.PARTIAL_MIN_CYC(2), .FULL_MIN_CYC(FULL_CYC)) DUT (
    .mclk(mclk), .rst_n(rst_n), .reset_pin_n(reset_pin_n), .ref_source_select(ref_sel),
    .sequencer_enable_pin(seq_pin), .range_mode_select_hi(rng_hi), .range_mode_select_lo(rng_lo),
    .interface_type_select(if_sel), .sw_range_cfg(sw_range_cfg), .conv_lsbs(conv_lsbs),
    .conv_read(conv_read), .reg_read(reg_read), .reg_rd_low(reg_rd_low), .reg_write(reg_write),
    .db_low_in(db_low_in), .shutdown_q(shutdown_q), .full_reset_done_q(full_reset_done_q),
    .partial_reset_done_q(partial_reset_done_q), .int_ref_enable_q(int_ref_enable_q),
    .ref_in_out_pin_oe_n_q(ref_in_out_pin_oe_n_q), .sequencer_on_q(sequencer_on_q),
    .sequencer_reduced_q(sequencer_reduced_q), .software_mode_q(software_mode_q),
    .serial_mode_q(serial_mode_q), .input_range_q(input_range_q), .reg_wr_low_q(reg_wr_low_q),
    .db_low_out_q(db_low_out_q), .db_low_oe_n_q(db_low_oe_n_q));

  spml_board_model board (
    .want_ref(want_ref), .want_seq(want_seq), .want_range(want_range), .want_serial(want_serial),
    .host_data(host_data), .db_low_out_q(db_low_out_q), .db_low_oe_n_q(db_low_oe_n_q),
    .ref_in_out_pin_oe_n_q(ref_in_out_pin_oe_n_q), .ref_source_select(ref_sel),
    .sequencer_enable_pin(seq_pin), .range_mode_select_hi(rng_hi), .range_mode_select_lo(rng_lo),
    .interface_type_select(if_sel), .ext_ref_driven(ext_ref), .db_low_in(db_low_in));

  initial
  begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  task step(input int n);
    repeat (n) @(posedge mclk);
    #2;
  endtask

  task chk1(input logic got, input logic exp, input string m);
    tests_run++;
    if (got !== exp)
    begin
      n_fail++;
      $display("MISMATCH %0t %s", $time, m);
    end
  endtask

  task chk4(input logic [3:0] got, input logic [3:0] exp, input string m);
    tests_run++;
    if (got !== exp)
    begin
      n_fail++;
      $display("MISMATCH %0t %s", $time, m);
    end
  endtask

  // Polls for the done pulse of the expected reset kind
  task pulse_seen(input bit full);
    int k;
    k = 0;
    while ((full ? full_reset_done_q : partial_reset_done_q) !== 1'b1 && k < 10)
    begin
      step(1);
      k++;
    end
    chk1(full ? full_reset_done_q : partial_reset_done_q, 1'b1, "reset done pulse missing");
    step(1);
  endtask

  task pin_reset(input int n);
    reset_pin_n = 1'b0;
    step(2);
    chk1(shutdown_q, 1'b1, "no shutdown while pin low");
    step(n - 2);
    reset_pin_n = 1'b1;
    pulse_seen(n >= FULL_CYC);
  endtask

  task t_hw_boot;
    pulse_seen(1'b1);
    chk1(int_ref_enable_q, 1'b0, "internal ref on");
    chk1(ref_in_out_pin_oe_n_q, 1'b1, "ref pin driven");
    chk1(ext_ref, 1'b1, "no external reference");
    chk1(sequencer_on_q, 1'b1, "sequencer off");
    chk1(sequencer_reduced_q, 1'b1, "sequencer not reduced");
    chk1(software_mode_q, 1'b0, "not hw mode");
    chk1(serial_mode_q, 1'b0, "not parallel");
    chk4({2'h0, input_range_q}, 4'h1, "range not 2.5");
  endtask

  task t_live_range;
    want_ref = 1'b1;
    want_seq = 1'b0;
    want_serial = 1'b1;
    for (int c = 1; c < 4; c++)
    begin
      want_range = c[1:0];
      step(2);
      chk4({2'h0, input_range_q}, c[3:0], "range not live");
    end
    want_range = 2'h0;
    step(2);
    chk1(software_mode_q, 1'b0, "mode relatched");
    chk1(int_ref_enable_q, 1'b0, "ref relatched");
    chk1(sequencer_on_q, 1'b1, "sequencer relatched");
    chk1(serial_mode_q, 1'b0, "interface relatched");
    want_serial = 1'b0;
    want_range = 2'h1;
  endtask

  task t_conv;
    conv_lsbs = 2'h2;
    conv_read = 1'b1;
    step(1);
    chk4(db_low_out_q, 4'h8, "conv lsb layout");
    chk4(db_low_oe_n_q, 4'h0, "conv not driven");
    conv_read = 1'b0;
    step(1);
    chk4(db_low_oe_n_q, 4'hF, "bus not released");
  endtask

  task t_partial;
    want_ref = 1'b1;
    want_serial = 1'b1;
    want_range = 2'h0;
    pin_reset(FULL_CYC - 1);
    chk1(int_ref_enable_q, 1'b0, "partial changed ref");
    chk1(serial_mode_q, 1'b0, "partial changed interface");
    chk1(software_mode_q, 1'b0, "partial changed mode");
  endtask

  task t_sw_full;
    want_seq = 1'b1;
    want_serial = 1'b0;
    sw_range_cfg = 2'h2;
    pin_reset(FULL_CYC + 2);
    chk1(int_ref_enable_q, 1'b1, "internal ref off");
    chk1(ref_in_out_pin_oe_n_q, 1'b0, "ref pin not driven");
    chk1(software_mode_q, 1'b1, "not sw mode");
    chk1(sequencer_on_q, 1'b0, "sequencer on");
    chk4({2'h0, input_range_q}, 4'h2, "sw range ignored");
    host_data = 4'hA;
    reg_write = 1'b1;
    step(1);
    reg_write = 1'b0;
    chk4(reg_wr_low_q, 4'hA, "write nibble");
    reg_rd_low = 4'h5;
    reg_read = 1'b1;
    conv_read = 1'b1;
    step(1);
    chk4(db_low_out_q, 4'h5, "read nibble");
    chk4(db_low_oe_n_q, 4'h0, "read not driven");
    reg_read = 1'b0;
    conv_read = 1'b0;
  endtask

  task t_serial;
    want_serial = 1'b1;
    want_range = 2'h1;
    want_seq = 1'b0;
    pin_reset(FULL_CYC + 2);
    chk1(serial_mode_q, 1'b1, "not serial");
    chk1(sequencer_on_q, 1'b0, "hw sequencer on with low strap");
    conv_read = 1'b1;
    step(1);
    chk4(db_low_oe_n_q, 4'hF, "parallel bus driven in serial");
    conv_read = 1'b0;
  endtask

  task summarize;
    if (n_fail == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  always @(posedge mclk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      n_fail++;
      summarize();
    end
  end

  initial
  begin
    {rst_n, reset_pin_n, want_ref, want_seq, want_range, want_serial} = 7'h2A;
    {host_data, sw_range_cfg, conv_lsbs, reg_rd_low, conv_read, reg_read, reg_write} = 15'h0;
    step(2);
    rst_n = 1'b1;
    t_hw_boot();
    t_live_range();
    t_conv();
    t_partial();
    t_sw_full();
    t_serial();
    summarize();
  end
endmodule
